// ---- hdl/spio_port.sv ----
`timescale 1ns/10ps
module spio_port
	import spio_pkg::*;
#(
	parameter bit HAS_REMAP = 1'b1
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// register port
	input wire logic [3:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [15:0] rdata_out,
	// peripheral side, per pin
	input wire logic [15:0] periph_en_in,
	input wire logic [15:0] periph_oe_in,
	input wire logic [15:0] periph_do_in,
	output logic [15:0] periph_di_out,
	// remappable function outputs, one bit per function number
	input wire logic [SPIO_NUM_FUNC-1:0] func_do_in,
	input wire logic [SPIO_NUM_FUNC-1:0] func_oe_in,
	// pads
	input wire logic [15:0] pad_in,
	output logic [15:0] pad_out,
	output logic [15:0] pad_oe_out
);

	////////////////////////////////////////////////////////////////////////////
	logic [15:0] pin_direction_reg;
	logic [15:0] pin_direction_next;
	logic [15:0] output_latch_reg;
	logic [15:0] output_latch_next;
	logic [15:0] remap_output_select_pair;
	logic [15:0] remap_next;
	logic [15:0] sync1_reg;
	logic [15:0] pin_level_reg;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;

	wire logic hit_dir = addr_in == SPIO_ADDR_DIR;
	wire logic hit_level = addr_in == SPIO_ADDR_LEVEL;
	wire logic hit_latch = addr_in == SPIO_ADDR_LATCH;
	wire logic hit_remap = HAS_REMAP && addr_in == SPIO_ADDR_REMAP;

	////////////////////////////////////////////////////////////////////////////
	// remap selectors choose a function's data and enable
	wire logic [SPIO_SEL_W-1:0] remap_sel_first_pin =
		remap_output_select_pair[SPIO_SEL_FIRST_LSB +: SPIO_SEL_W];
	wire logic [SPIO_SEL_W-1:0] remap_sel_second_pin =
		remap_output_select_pair[SPIO_SEL_SECOND_LSB +: SPIO_SEL_W];
	// function zero is "none": selector cleared leaves the pin to the port
	wire logic first_oe = HAS_REMAP && remap_sel_first_pin != 5'h0_0 &&
		func_oe_in[remap_sel_first_pin];
	wire logic second_oe = HAS_REMAP && remap_sel_second_pin != 5'h0_0 &&
		func_oe_in[remap_sel_second_pin];
	wire logic first_do = func_do_in[remap_sel_first_pin];
	wire logic second_do = func_do_in[remap_sel_second_pin];

	logic [15:0] eff_oe;
	logic [15:0] eff_do;
	always_comb begin
		eff_oe = periph_en_in & periph_oe_in;
		eff_do = periph_do_in;
		eff_oe[SPIO_FIRST_PIN] = eff_oe[SPIO_FIRST_PIN] | first_oe;
		eff_do[SPIO_FIRST_PIN] = first_oe ? first_do : periph_do_in[SPIO_FIRST_PIN];
		eff_oe[SPIO_SECOND_PIN] = eff_oe[SPIO_SECOND_PIN] | second_oe;
		eff_do[SPIO_SECOND_PIN] = second_oe ? second_do : periph_do_in[SPIO_SECOND_PIN];
	end

	////////////////////////////////////////////////////////////////////////////
	// peripheral owns when driving
	// port driver off while peripheral drives
	// input-only peripherals never assert oe, so the port keeps the pin
	wire logic [15:0] port_oe = ~pin_direction_reg & SPIO_VALID_MASK;
	assign pad_oe_out = (eff_oe | port_oe) & SPIO_VALID_MASK;
	// per-bit select: a whole-word condition would hand every pin to one peripheral
	wire logic [15:0] port_do = output_latch_reg & ~eff_oe;
	assign pad_out = ((eff_oe & eff_do) | port_do) & SPIO_VALID_MASK;

	// no loop-through
	// peripheral sees the pad only while the port is not the driver
	assign periph_di_out = pad_in & ~(port_oe & ~eff_oe);

	////////////////////////////////////////////////////////////////////////////
	// register writes
	// latch write
	assign output_latch_next = (wr_in && (hit_latch || hit_level)) ?
		(wdata_in & SPIO_VALID_MASK) : output_latch_reg;
	assign pin_direction_next = (wr_in && hit_dir) ?
		(wdata_in & SPIO_VALID_MASK) : pin_direction_reg;
	assign remap_next = (wr_in && hit_remap) ?
		(wdata_in & SPIO_REMAP_MASK) : remap_output_select_pair;

	// read mux; unmapped and absent addresses read zero
	// absent remap reads zero
	assign rdata_next = !rd_in ? 16'h0000 :
		hit_dir ? (pin_direction_reg & SPIO_VALID_MASK) :
		hit_level ? (pin_level_reg & SPIO_VALID_MASK) :
		hit_latch ? output_latch_reg :
		hit_remap ? remap_output_select_pair : 16'h0000;
	assign rdata_out = rdata_reg;

	////////////////////////////////////////////////////////////////////////////
	// reset to inputs
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			pin_direction_reg <= SPIO_DIR_RESET;
			output_latch_reg <= SPIO_LATCH_RESET;
			remap_output_select_pair <= SPIO_REMAP_RESET;
			rdata_reg <= 16'h0000;
		end else begin
			pin_direction_reg <= pin_direction_next;
			output_latch_reg <= output_latch_next;
			remap_output_select_pair <= remap_next;
			rdata_reg <= rdata_next;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			sync1_reg <= 16'h0000;
			pin_level_reg <= 16'h0000;
		end else begin
			sync1_reg <= pad_in;
			pin_level_reg <= sync1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// assertions
	logic [15:0] pad_d1;
	logic [15:0] pad_d2;
	always_ff @(posedge clk_in) begin
		pad_d1 <= pad_in;
		pad_d2 <= pad_d1;
	end

	dir_reset_a: assert property (
		@(posedge clk_in) !rst_b_in |=> pin_direction_reg == SPIO_DIR_RESET && pad_oe_out ==
		(eff_oe & SPIO_VALID_MASK))
		else $error("direction not all inputs after reset");

	periph_owns_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		(pad_oe_out & eff_oe) == (eff_oe & SPIO_VALID_MASK) &&
		((pad_out ^ eff_do) & eff_oe & SPIO_VALID_MASK) == 16'h0000)
		else $error("peripheral lost pin ownership");

	port_drive_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		((pad_out ^ output_latch_reg) & ~eff_oe & ~pin_direction_reg & SPIO_VALID_MASK)
		== 16'h0000)
		else $error("output pin does not follow latch");

	idle_periph_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		(pad_oe_out & ~eff_oe) == (~pin_direction_reg & ~eff_oe & SPIO_VALID_MASK))
		else $error("port cannot drive idle shared pin");

	no_loop_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		(periph_di_out & ~pin_direction_reg & ~eff_oe) == 16'h0000)
		else $error("port output looped into peripheral");

	latch_rw_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		wr_in && hit_latch ##1 rd_in && hit_latch && !wr_in |=>
		rdata_out == $past(output_latch_reg))
		else $error("latch readback mismatch");

	level_write_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		wr_in && hit_level |=> output_latch_reg == $past(wdata_in & SPIO_VALID_MASK))
		else $error("level write missed latch");

	level_sync_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		rd_in && hit_level && $past(rst_b_in, 3) |=> rdata_out == $past(pad_d2))
		else $error("pin level read not two stages late");

	remap_zero_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		rd_in && addr_in == SPIO_ADDR_REMAP |=> (rdata_out & ~SPIO_REMAP_MASK) == 16'h0000)
		else $error("remap unused bits not zero");

	remap_sel_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		wr_in && hit_remap |=> remap_sel_second_pin == $past(wdata_in[12:8]) &&
		remap_sel_first_pin == $past(wdata_in[4:0]))
		else $error("remap selector fields misplaced");

	////////////////////////////////////////////////////////////////////////////
	// register bus: writes land once, reads answer one cycle
	rdata_idle_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		!rd_in |=>
		rdata_out == 16'h0000)
		else $error("read data not cleared after read cycle");

	dir_write_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		wr_in && hit_dir |=>
		pin_direction_reg == $past(wdata_in & SPIO_VALID_MASK))
		else $error("direction write lost");

	dir_hold_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		!(wr_in && hit_dir) |=>
		$stable(pin_direction_reg))
		else $error("direction changed without write");

	latch_hold_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		!(wr_in && (hit_latch || hit_level)) |=>
		$stable(output_latch_reg))
		else $error("latch changed without write");

	remap_hold_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		!(wr_in && hit_remap) |=>
		$stable(remap_output_select_pair))
		else $error("remap changed without write");

	dir_read_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		rd_in && hit_dir |=>
		rdata_out == $past(pin_direction_reg))
		else $error("direction readback mismatch");

	latch_read_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		rd_in && hit_latch |=>
		rdata_out == $past(output_latch_reg))
		else $error("latch read does not return latch");

	remap_read_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		rd_in && hit_remap |=>
		rdata_out == $past(remap_output_select_pair))
		else $error("remap readback mismatch");

	////////////////////////////////////////////////////////////////////////////
	// small package: remap register absent, its address reads zero
	remap_absent_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		rd_in && !HAS_REMAP && addr_in == SPIO_ADDR_REMAP |=>
		rdata_out == 16'h0000)
		else $error("absent remap register read nonzero");

	remap_empty_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		!HAS_REMAP |->
		remap_output_select_pair == 16'h0000)
		else $error("absent remap register holds a value");

	unmapped_read_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		rd_in && addr_in > SPIO_ADDR_REMAP |=>
		rdata_out == 16'h0000)
		else $error("unmapped address read nonzero");

	////////////////////////////////////////////////////////////////////////////
	// pin ownership and direction
	input_pin_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		(pad_oe_out & pin_direction_reg & ~eff_oe) ==
		16'h0000)
		else $error("input pin driven by port");

	invalid_drive_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		(pad_oe_out & ~SPIO_VALID_MASK) == 16'h0000 &&
		(pad_out & ~SPIO_VALID_MASK) == 16'h0000)
		else $error("invalid bit driven");

	periph_view_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		((periph_di_out ^ pad_in) & ~(port_oe & ~eff_oe)) ==
		16'h0000)
		else $error("peripheral input lost pad level");

	input_only_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		((pad_out ^ output_latch_reg) & periph_en_in & ~eff_oe & port_oe) ==
		16'h0000)
		else $error("non-driving peripheral blocked port");

	// reading the pin must work even while a peripheral owns it
	level_owned_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		rd_in && hit_level && eff_oe != 16'h0000 && $past(rst_b_in, 3) |=>
		rdata_out == $past(pad_d2))
		else $error("owned pin not readable");

	////////////////////////////////////////////////////////////////////////////
	// remapped function outputs reach their pins
	remap_first_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		HAS_REMAP && remap_sel_first_pin != 5'h00 && func_oe_in[remap_sel_first_pin] |->
		pad_oe_out[SPIO_FIRST_PIN] && pad_out[SPIO_FIRST_PIN] == first_do)
		else $error("first remap pin not driven by function");

	remap_second_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		HAS_REMAP && remap_sel_second_pin != 5'h00 && func_oe_in[remap_sel_second_pin] |->
		pad_oe_out[SPIO_SECOND_PIN] && pad_out[SPIO_SECOND_PIN] == second_do)
		else $error("second remap pin not driven by function");

	////////////////////////////////////////////////////////////////////////////
	// synchroniser stages; each guarded until its own stage left reset
	sync_first_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		$past(rst_b_in) |->
		sync1_reg == $past(pad_in))
		else $error("first sync stage wrong");

	sync_second_a: assert property (
		@(posedge clk_in) disable iff (!rst_b_in)
		$past(rst_b_in, 2) |->
		pin_level_reg == $past(sync1_reg))
		else $error("second sync stage wrong");

endmodule : spio_port

// ---- hdl/spio_pkg.sv ----
package spio_pkg;
	// port geometry
	localparam int SPIO_WIDTH = 16;
	localparam logic [15:0] SPIO_VALID_MASK = 16'hFFFF;
	// register map (word addresses)
	localparam logic [3:0] SPIO_ADDR_DIR = 4'h0;
	localparam logic [3:0] SPIO_ADDR_LEVEL = 4'h1;
	localparam logic [3:0] SPIO_ADDR_LATCH = 4'h2;
	localparam logic [3:0] SPIO_ADDR_REMAP = 4'h3;
	// reset values
	localparam logic [15:0] SPIO_DIR_RESET = 16'hFFFF;
	localparam logic [15:0] SPIO_LATCH_RESET = 16'h0000;
	localparam logic [15:0] SPIO_REMAP_RESET = 16'h0000;
	// remap selector fields
	localparam int SPIO_SEL_W = 5;
	localparam int SPIO_SEL_FIRST_LSB = 0;
	localparam int SPIO_SEL_SECOND_LSB = 8;
	localparam logic [15:0] SPIO_REMAP_MASK = 16'h1F1F;
	// remappable pins' positions in the port
	localparam int SPIO_FIRST_PIN = 8;
	localparam int SPIO_SECOND_PIN = 9;
	localparam int SPIO_NUM_FUNC = 32;
endpackage : spio_pkg

// ---- bench/spio_pad_model.sv ----
`timescale 1ns/10ps
// pads and outside world: each pad shows what drives it
module spio_pad_model (
	// from the port
	input wire logic [15:0] pad_out_in,
	input wire logic [15:0] pad_oe_in,
	// outside driver level
	input wire logic [15:0] ext_in,
	// to the port
	output logic [15:0] pad_in_out
);
	// no pull resistors, so an undriven pad takes the outside level
	assign pad_in_out = (pad_oe_in & pad_out_in) | (~pad_oe_in & ext_in);
endmodule : spio_pad_model

// ---- bench/shared_pin_parallel_io_port_tb_top.sv ----
`timescale 1ns/10ps
module shared_pin_parallel_io_port_tb_top
	import spio_pkg::*;
;
	logic clk_in = 1'b0, rst_b_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
	logic [3:0] addr_in = 4'h0;
	logic [15:0] wdata_in = 16'h0000, rdata_out, periph_di_out, pad_in, pad_out, pad_oe_out;
	logic [15:0] periph_en_in = 16'h0000, periph_oe_in = 16'h0000, periph_do_in = 16'h0000;
	logic [15:0] ext = 16'h0000;
	logic [15:0] rdata_small;
	logic [SPIO_NUM_FUNC-1:0] func_do_in = '0, func_oe_in = '0;
	int err_count = 0, comparisons = 0;
	always #50 clk_in = ~clk_in;
	spio_port #(.HAS_REMAP(1'b1)) uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.periph_en_in(periph_en_in), .periph_oe_in(periph_oe_in), .periph_do_in(periph_do_in),
		.periph_di_out(periph_di_out), .func_do_in(func_do_in), .func_oe_in(func_oe_in),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe_out(pad_oe_out));
	spio_port #(.HAS_REMAP(1'b0)) uut_small (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_small), .periph_en_in(periph_en_in), .periph_oe_in(periph_oe_in),
		.periph_do_in(periph_do_in), .periph_di_out(), .func_do_in(func_do_in),
		.func_oe_in(func_oe_in), .pad_in(pad_in), .pad_out(), .pad_oe_out());
	spio_pad_model pads (.pad_out_in(pad_out), .pad_oe_in(pad_oe_out), .ext_in(ext),
		.pad_in_out(pad_in));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 chk("rdata", e, rdata_out);
	endtask : rd
	// write then read with no gap between the strobes
	task automatic wr_rd(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 chk("rdata", d, rdata_out);
	endtask : wr_rd
	// three edges cover the two-flop pin synchroniser
	task automatic settle();
		repeat (3) @(posedge clk_in);
		#1;
	endtask : settle
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#100_000;
		err_count++;
		end_sim();
	end
	initial begin
		repeat (16) @(posedge clk_in);
		rst_b_in <= 1'b1;
		rd(SPIO_ADDR_DIR, 16'hFFFF);
		rd(SPIO_ADDR_LATCH, 16'h0000);
		rd(SPIO_ADDR_REMAP, 16'h0000);
		chk("pad_oe", 16'h0000, pad_oe_out);
		wr(SPIO_ADDR_LATCH, 16'hA5A5);
		wr(SPIO_ADDR_DIR, 16'h0000);
		rd(SPIO_ADDR_LATCH, 16'hA5A5);
		settle();
		chk("pad_oe", 16'hFFFF, pad_oe_out);
		chk("pad_out", 16'hA5A5, pad_out);
		rd(SPIO_ADDR_LEVEL, 16'hA5A5);
		wr(SPIO_ADDR_LEVEL, 16'h3C3E);
		rd(SPIO_ADDR_LATCH, 16'h3C3E);
		periph_en_in <= 16'h0003;
		periph_oe_in <= 16'h0001;
		periph_do_in <= 16'h0001;
		settle();
		chk("pad_out", 16'h3C3F, pad_out);
		chk("pad_oe", 16'hFFFF, pad_oe_out);
		chk("periph_di", 16'h0001, periph_di_out & 16'h0003);
		rd(SPIO_ADDR_LEVEL, 16'h3C3F);
		wr(SPIO_ADDR_DIR, 16'hFFFF);
		ext <= 16'h5A5A;
		settle();
		chk("pad_oe", 16'h0001, pad_oe_out);
		periph_en_in <= 16'h0000;
		periph_oe_in <= 16'h0000;
		settle();
		rd(SPIO_ADDR_LEVEL, 16'h5A5A);
		wr(SPIO_ADDR_REMAP, 16'hFFFF);
		rd(SPIO_ADDR_REMAP, 16'h1F1F);
		wr(SPIO_ADDR_REMAP, 16'h0403);
		rd(SPIO_ADDR_REMAP, 16'h0403);
		chk("rdata_small", 16'h0000, rdata_small);
		func_oe_in <= 32'h0000_0018;
		func_do_in <= 32'h0000_0008;
		settle();
		chk("pad_oe", 16'h0300, pad_oe_out);
		chk("pad_out", 16'h0100, pad_out & 16'h0300);
		wr_rd(SPIO_ADDR_LATCH, 16'h1234);
		wr(4'h7, 16'h0000);
		rd(4'h7, 16'h0000);
		rd(SPIO_ADDR_DIR, 16'hFFFF);
		end_sim();
	end
endmodule : shared_pin_parallel_io_port_tb_top
